// *** hdl/coms_top.sv ***
// Purpose: Output method selection: heat, cool, heat-cool, position, ON/OFF
// Assumes: Wishbone classic slave, PV and SP written by software
// Notes: Proportional MV is computed from deviation, band and gain
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module coms_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic valve_full_pin,
    input wire logic [3:0] valve_pos_pin,
    output logic ctl_out1,
    output logic ctl_out2,
    output logic bumpless_risk,
    output logic [3:0] bar_graph,
    output logic feat_disable
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Merge write data into a word by byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // Saturate a signed value to per mille range 0..1000
    function automatic logic [15:0] sat_mv(input logic signed [31:0] v);
        logic [15:0] r;
        r = 16'h0000;
        if (v > 32'sd1000) r = 16'h03E8;
        else if (v > 32'sd0) r = v[15:0];
        return r;
    endfunction : sat_mv

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Everything the block remembers except travel time and calibration, registered as one word
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] band;
        logic [15:0] gain;
        logic [15:0] pb;
        logic [15:0] stop_mv;
        logic [31:0] hyst;
        logic [31:0] proc_v;
        logic [31:0] valve;
        logic [15:0] pid_mv;
        logic [15:0] ms_cnt;
        logic ms_tick;
        logic [31:0] dat;
        logic ack;
        logic refused;
        logic heat_on;
        logic cool_on;
        logic cal_go;
        logic [1:0] full_sync;
        logic [7:0] pos_sync;
        logic feat_off;    // Feature disable in position mode
        coms_pkg::coms_out_s outs;
    } coms_top_s;

    coms_top_s s_r;   // Registered state
    coms_top_s s_nxt; // Next state

    logic [15:0] travel_s; // Travel time from timer
    logic cal_busy;        // Calibration running
    logic wr_travel;       // Direct travel write strobe

    // ------------------------------------------------------------
    // Travel time and calibration
    // ------------------------------------------------------------
    // Timer owns the travel time so calibration and writes share it
    coms_travel u_travel (
        .clk(clk),
        .rst(rst),
        .ms_tick(s_r.ms_tick),
        .cal_start(s_r.cal_go),
        .full_open(s_r.full_sync[1]),
        .wr_travel(wr_travel),
        .wr_value(wb_dat_i[15:0]),
        .travel_s(travel_s),
        .cal_busy(cal_busy)
    );

    // Direct write strobe, same qualification as the bus decode
    assign wr_travel = wb_cyc_i && wb_stb_i && wb_we_i && !s_r.ack
                       && wb_adr_i == coms_pkg::ADR_TRAVEL;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        // Working values, each assigned before it is used
        logic wr;
        logic rd;
        logic [31:0] nv;
        coms_pkg::coms_ctrl_s c;
        logic signed [15:0] pv;
        logic signed [15:0] sp;
        logic signed [15:0] bw;
        logic signed [15:0] half;
        logic signed [31:0] dev;
        logic signed [31:0] ehot;
        logic signed [31:0] ecold;
        logic signed [31:0] pbc;
        logic signed [31:0] pbh;
        logic signed [15:0] hh;
        logic signed [15:0] hc;
        logic signed [15:0] smv;
        logic hc_mode;
        logic pos_mode;
        coms_pkg::coms_valve_e va;
        s_nxt = s_r;
        wr = 1'b0;
        rd = 1'b0;
        nv = 32'h0000_0000;
        // Unpack the control word into named fields
        c = '{method: coms_pkg::coms_method_e'(s_r.ctrl[1:0]),
              onoff: s_r.ctrl[coms_pkg::CTRL_ONOFF_BIT],
              run: s_r.ctrl[coms_pkg::CTRL_RUN_BIT],
              direct: s_r.ctrl[coms_pkg::CTRL_DIRECT_BIT],
              pv_err: s_r.ctrl[coms_pkg::CTRL_PVERR_BIT],
              pot_ok: s_r.ctrl[coms_pkg::CTRL_POT_BIT]};
        // Signed process values, band and stop MV
        pv = s_r.proc_v[15:0];
        sp = s_r.proc_v[31:16];
        bw = s_r.band;
        smv = s_r.stop_mv;
        // Method decode shared by several branches
        hc_mode = (c.method == coms_pkg::COMS_HEATCOOL);
        pos_mode = (c.method == coms_pkg::COMS_POSITION);
        va = coms_pkg::COMS_HOLD;

        // Millisecond enable divider
        s_nxt.ms_tick = 1'b0;
        if (s_r.ms_cnt == coms_pkg::MS_LAST) begin
            s_nxt.ms_cnt = 16'h0000;
            s_nxt.ms_tick = 1'b1;
        end else begin
            s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
        end

        // Pin synchronisers
        s_nxt.full_sync = {s_r.full_sync[0], valve_full_pin};
        s_nxt.pos_sync = {s_r.pos_sync[3:0], valve_pos_pin};

        // Wishbone: one wait state, ack dropped after one cycle
        s_nxt.ack = 1'b0;
        s_nxt.cal_go = 1'b0;
        if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
            s_nxt.ack = 1'b1;
            wr = wb_we_i;
            rd = !wb_we_i;
        end
        // Register writes land on the edge that takes the request
        if (wr) begin
            case (wb_adr_i)
                coms_pkg::ADR_CTRL: begin
                    nv = merge(s_r.ctrl, wb_dat_i, wb_sel_i);
                    // Position type cannot pick ON/OFF
                    if (nv[1:0] == coms_pkg::COMS_POSITION && nv[coms_pkg::CTRL_ONOFF_BIT]) begin
                        nv[coms_pkg::CTRL_ONOFF_BIT] = 1'b0;
                        s_nxt.refused = 1'b1;
                    end
                    s_nxt.cal_go = nv[coms_pkg::CTRL_CAL_BIT]
                                   && nv[1:0] == coms_pkg::COMS_POSITION;
                    nv[coms_pkg::CTRL_CAL_BIT] = 1'b0;
                    nv[31:8] = 24'h000000;
                    s_nxt.ctrl = nv;
                end
                coms_pkg::ADR_BAND: s_nxt.band = wb_dat_i[15:0];
                coms_pkg::ADR_GAIN: s_nxt.gain = wb_dat_i[15:0];
                coms_pkg::ADR_PB: s_nxt.pb = wb_dat_i[15:0];
                coms_pkg::ADR_STOPMV: s_nxt.stop_mv = wb_dat_i[15:0];
                coms_pkg::ADR_HYST: s_nxt.hyst = merge(s_r.hyst, wb_dat_i, wb_sel_i);
                coms_pkg::ADR_PROC: s_nxt.proc_v = merge(s_r.proc_v, wb_dat_i, wb_sel_i);
                coms_pkg::ADR_VALVE: s_nxt.valve = {28'h0000000, wb_dat_i[3:0]};
                coms_pkg::ADR_PIDMV: s_nxt.pid_mv = wb_dat_i[15:0];
                default: begin
                    // Unmapped or read-only address: write ignored; a travel write goes to the timer
                end
            endcase
        end
        // Read data, registered so it stands together with ack
        s_nxt.dat = 32'h0000_0000;
        if (rd) begin
            case (wb_adr_i)
                coms_pkg::ADR_CTRL: s_nxt.dat = s_r.ctrl;
                coms_pkg::ADR_BAND: s_nxt.dat = hc_mode ? {16'h0000, s_r.band} : 32'h0;
                coms_pkg::ADR_GAIN: s_nxt.dat = hc_mode ? {16'h0000, s_r.gain} : 32'h0;
                coms_pkg::ADR_PB: s_nxt.dat = {16'h0000, s_r.pb};
                coms_pkg::ADR_STOPMV: s_nxt.dat = {16'h0000, s_r.stop_mv};
                coms_pkg::ADR_HYST: s_nxt.dat = s_r.hyst;
                coms_pkg::ADR_PROC: s_nxt.dat = s_r.proc_v;
                coms_pkg::ADR_TRAVEL: s_nxt.dat = {16'h0000, travel_s};
                coms_pkg::ADR_VALVE: s_nxt.dat = {s_r.pos_sync[7:4], 24'h000000, s_r.valve[3:0]};
                coms_pkg::ADR_STAT: s_nxt.dat = {26'h0, pos_mode, cal_busy, s_r.refused,
                                                 s_r.outs.bumpless_risk, s_r.cool_on, s_r.heat_on};
                coms_pkg::ADR_PIDMV: s_nxt.dat = {16'h0000, s_r.pid_mv};
                default: s_nxt.dat = 32'h0000_0000;
            endcase
            // Reading status clears the refused flag
            if (wb_adr_i == coms_pkg::ADR_STAT) s_nxt.refused = 1'b0;
        end

        // ------------------------------------------------------------
        // Control law
        // ------------------------------------------------------------
        // Deviation, signed so that positive wants heat
        dev = c.direct ? 32'(pv) - 32'(sp) : 32'(sp) - 32'(pv);
        half = hc_mode ? (bw >>> 1) : 16'sh0000;
        ehot = dev - 32'(half);  // Heat starts past half band above SP side
        ecold = -dev - 32'(half); // Negative band lets both overlap
        pbc = (32'(s_r.gain) * 32'(s_r.pb)) >>> 8;
        pbh = $signed({16'h0000, s_r.pb}); // Signed so negative errors divide right
        hh = s_r.hyst[15:0];
        hc = c.method == coms_pkg::COMS_HEATCOOL ? s_r.hyst[31:16] : 16'sh0000;

        // Output selection by method and algorithm
        if (pos_mode) begin
            // Valve: open or close from the sign of the deviation, or fixed action
            if (!c.run) va = coms_pkg::coms_valve_e'(s_r.valve[1:0]);
            else if (c.pv_err) va = coms_pkg::coms_valve_e'(s_r.valve[3:2]);
            else if (dev > 32'sd0) va = coms_pkg::COMS_OPEN;
            else if (dev < 32'sd0) va = coms_pkg::COMS_CLOSE;
            // Open drives output one, close drives output two
            s_nxt.heat_on = (va == coms_pkg::COMS_OPEN);
            s_nxt.cool_on = (va == coms_pkg::COMS_CLOSE);
        end else if (!c.run) begin
            // Stopped: sign of stop MV picks the side
            s_nxt.heat_on = smv > 16'sh0000;
            s_nxt.cool_on = hc_mode && smv < 16'sh0000;
        end else if (c.onoff) begin
            // ON/OFF with hysteresis per side
            if (ehot > 32'sd0) s_nxt.heat_on = 1'b1;
            else if (ehot < -32'(hh)) s_nxt.heat_on = 1'b0;
            // Cooling side exists only in heat-cool
            if (!hc_mode) s_nxt.cool_on = 1'b0;
            else if (ecold > 32'sd0) s_nxt.cool_on = 1'b1;
            else if (ecold < -32'(hc)) s_nxt.cool_on = 1'b0;
        end else begin
            // PID: proportional share against the side band
            // Heating side uses the common band unchanged
            s_nxt.heat_on = 32'(sat_mv((ehot * 32'sd1000) / (pbh + 32'sd1)))
                            > 32'(s_r.pid_mv[15:0]) || ehot > 32'sd0 && s_r.pb == 16'h0;
            s_nxt.cool_on = hc_mode && ecold > 32'sd0
                            && 32'(sat_mv((ecold * 32'sd1000) / (pbc + 32'sd1))) > 32'sd0;
        end

        // Output image, registered so every pin comes from a flip-flop
        s_nxt.outs.out1 = s_nxt.heat_on;
        s_nxt.outs.out2 = s_nxt.cool_on;
        s_nxt.outs.bumpless_risk = hc_mode && bw < 16'sh0000;
        s_nxt.outs.bar = (pos_mode && c.pot_ok) ? s_r.pos_sync[7:4] : 4'h0;
        s_nxt.feat_off = pos_mode;
    end

    // State register, reset to heating reverse PID
    always_ff @(posedge clk) begin
        if (rst) begin
            // Clear everything, then load the gain and stop MV defaults
            s_r <= '0;
            s_r.gain <= coms_pkg::GAIN_RST;
            s_r.stop_mv <= coms_pkg::STOPMV_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus answer
    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    // Actuator drive and indicators
    assign ctl_out1 = s_r.outs.out1;
    assign ctl_out2 = s_r.outs.out2;
    assign bumpless_risk = s_r.outs.bumpless_risk;
    assign bar_graph = s_r.outs.bar;
    // ST, limiter, P/PD, 40% AT, loop-break and burnout disabled
    assign feat_disable = s_r.feat_off;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // A stored control word never pairs position with ON/OFF
    a_onoff_refused: assert property (@(posedge clk) disable iff (rst)
        s_r.ctrl[1:0] == coms_pkg::COMS_POSITION |-> !s_r.ctrl[coms_pkg::CTRL_ONOFF_BIT])
        else $error("onoff in position");
    // Valve open and close are never driven together
    a_pos_exclusive: assert property (@(posedge clk) disable iff (rst)
        s_r.ctrl[1:0] == coms_pkg::COMS_POSITION |=> !(ctl_out1 && ctl_out2))
        else $error("valve both");
    // Zero stop MV leaves both outputs off outside position mode
    a_stop_zero: assert property (@(posedge clk) disable iff (rst)
        s_r.ctrl[1:0] != coms_pkg::COMS_POSITION && !s_r.ctrl[coms_pkg::CTRL_RUN_BIT]
        && s_r.stop_mv == 16'h0000 |=> !ctl_out1 && !ctl_out2)
        else $error("output at zero stop mv");
    // Negative stop MV in heat-cool never heats
    a_stop_sign: assert property (@(posedge clk) disable iff (rst)
        s_r.ctrl[1:0] == coms_pkg::COMS_HEATCOOL && !s_r.ctrl[coms_pkg::CTRL_RUN_BIT]
        && s_r.stop_mv[15] |=> !ctl_out1)
        else $error("heat on negative stop");
    // Positive or zero stop MV never cools
    a_stop_cool: assert property (@(posedge clk) disable iff (rst)
        s_r.ctrl[1:0] != coms_pkg::COMS_POSITION && !s_r.ctrl[coms_pkg::CTRL_RUN_BIT]
        && !s_r.stop_mv[15] |=> !ctl_out2)
        else $error("cool on positive stop");
    // Band reads as zero outside heat-cool
    a_band_hidden: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o && $past(!wb_we_i && wb_adr_i == coms_pkg::ADR_BAND
        && s_r.ctrl[1:0] != coms_pkg::COMS_HEATCOOL) |-> wb_dat_o == 32'h0000_0000)
        else $error("band visible");
    // Negative band in heat-cool raises the bumpless warning
    a_bump_flag: assert property (@(posedge clk) disable iff (rst)
        s_r.ctrl[1:0] == coms_pkg::COMS_HEATCOOL && s_r.band[15] |=> bumpless_risk)
        else $error("no flag");
    // Bar graph stays dark without a calibrated potentiometer
    a_bar_gate: assert property (@(posedge clk) disable iff (rst)
        !s_r.ctrl[coms_pkg::CTRL_POT_BIT] |=> bar_graph == 4'h0)
        else $error("bar without pot");
    // Standard heat or cool methods never drive output two
    a_cool_std: assert property (@(posedge clk) disable iff (rst)
        s_r.ctrl[1:0] == coms_pkg::COMS_HEAT || s_r.ctrl[1:0] == coms_pkg::COMS_COOL
        |=> !ctl_out2)
        else $error("cool in standard");
    // Position mode turns the unsupported features off
    a_feat_pos: assert property (@(posedge clk) disable iff (rst)
        s_r.ctrl[1:0] == coms_pkg::COMS_POSITION |=> feat_disable)
        else $error("features left on in position");
    // Acknowledge is a single-cycle pulse
    a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack long");

endmodule : coms_top

// *** inc/coms_pkg.sv ***
// Purpose: Constants and carrier types for the control output method select block
// Assumes: 20 MHz clock, classic Wishbone slave with 32-bit data
// Notes: Overview list of behaviour follows
// Overview of operation
// - Reset gives heating, output one heat, reverse
// - Band and cool gain only in heat-cool
// - Positive width dead band, negative overlap band
// - Cool band is gain times common band
// - Stopped: negative MV cools in heat-cool, positive heats
// - Stop MV resets to zero, no output
// - Position type: out1 opens, out2 closes
// - Position type disables ST, limiter, PD, etc
// - Travel time 30 s, set or calibrate
// - Valve opening on bar graph, 10% steps
// - Stop and PV error pick open/close/hold
// - Algorithm select PID or ON/OFF, PID default
// - ON/OFF refused in position type
// - ON/OFF uses separate heat, cool hysteresis
// - Standard control uses heat hysteresis only
// - Heat-cool ON/OFF gives three output states
// - Overlap band flags bumpless not guaranteed
package coms_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;   // Method, algorithm, run, direction
    localparam logic [7:0] ADR_BAND = 8'h04;   // Heat-cool band width, signed
    localparam logic [7:0] ADR_GAIN = 8'h08;   // Cooling gain, 8.8 fixed point
    localparam logic [7:0] ADR_PB = 8'h0C;     // Common proportional band
    localparam logic [7:0] ADR_STOPMV = 8'h10; // Stop MV, signed per mille
    localparam logic [7:0] ADR_HYST = 8'h14;   // Heat [15:0], cool [31:16] hysteresis
    localparam logic [7:0] ADR_PROC = 8'h18;   // PV [15:0], SP [31:16], signed
    localparam logic [7:0] ADR_TRAVEL = 8'h1C; // Travel time in seconds
    localparam logic [7:0] ADR_VALVE = 8'h20;  // Valve actions and opening
    localparam logic [7:0] ADR_STAT = 8'h24;   // Status, read only
    localparam logic [7:0] ADR_PIDMV = 8'h28;  // MV from PID, signed per mille

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTRL_METHOD_LSB = 0;  // Two bits
    localparam int CTRL_ONOFF_BIT = 2;
    localparam int CTRL_RUN_BIT = 3;
    localparam int CTRL_DIRECT_BIT = 4;
    localparam int CTRL_PVERR_BIT = 5;
    localparam int CTRL_CAL_BIT = 6;     // Start calibration, self clearing
    localparam int CTRL_POT_BIT = 7;     // Potentiometer calibrated

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] TRAVEL_RST_S = 16'h001E;    // 30 seconds
    localparam logic [15:0] STOPMV_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST = 16'h0100;        // Gain of one
    localparam int CLK_HZ = 20_000_000;
    localparam int SEC_MS = 1000;
    localparam int MS_CYCLES = CLK_HZ / SEC_MS;         // One millisecond tick
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
    localparam logic [15:0] SEC_LAST_MS = 16'(SEC_MS - 1);

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        COMS_HEAT = 2'h0,
        COMS_COOL = 2'h1,
        COMS_HEATCOOL = 2'h2,
        COMS_POSITION = 2'h3
    } coms_method_e;

    typedef enum logic [1:0] {
        COMS_HOLD = 2'h0,
        COMS_OPEN = 2'h1,
        COMS_CLOSE = 2'h2
    } coms_valve_e;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_RUN = 3'b010,
        CAL_DONE = 3'b100
    } coms_cal_e;

    // ------------------------------------------------------------
    // Carrier structs
    // ------------------------------------------------------------
    typedef struct packed {
        coms_method_e method;
        logic onoff;
        logic run;
        logic direct;
        logic pv_err;
        logic pot_ok;
    } coms_ctrl_s;

    typedef struct packed {
        logic out1;        // Heat or valve open
        logic out2;        // Cool or valve close
        logic bumpless_risk;
        logic [3:0] bar;   // Bar graph steps of 10%
    } coms_out_s;

endpackage : coms_pkg

// *** hdl/coms_travel.sv ***
// Purpose: Travel time timer and motor calibration sequencer
// Assumes: One millisecond enable from the parent
// Notes: Calibration times the stroke until the full-open switch; it does not drive the open output itself
`timescale 1ns/1ps
module coms_travel (
    input wire logic clk,
    input wire logic rst,
    input wire logic ms_tick,
    input wire logic cal_start,
    input wire logic full_open,
    input wire logic wr_travel,
    input wire logic [15:0] wr_value,
    output logic [15:0] travel_s,
    output logic cal_busy
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        coms_pkg::coms_cal_e st;
        logic [15:0] travel;
        logic [15:0] ms_cnt;
        logic [15:0] sec_cnt;
    } coms_trv_s;

    coms_trv_s s_r;   // Registered state
    coms_trv_s s_nxt; // Next state

    // Next state: direct write or calibration stroke timing
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            coms_pkg::CAL_IDLE: begin
                if (cal_start) begin
                    s_nxt.st = coms_pkg::CAL_RUN;
                    s_nxt.ms_cnt = 16'h0000;
                    s_nxt.sec_cnt = 16'h0000;
                end else if (wr_travel) begin
                    s_nxt.travel = wr_value;
                end
            end
            coms_pkg::CAL_RUN: begin
                if (full_open) begin
                    s_nxt.st = coms_pkg::CAL_DONE;
                end else if (ms_tick) begin
                    if (s_r.ms_cnt == coms_pkg::SEC_LAST_MS) begin
                        s_nxt.ms_cnt = 16'h0000;
                        s_nxt.sec_cnt = s_r.sec_cnt + 16'h0001;
                    end else begin
                        s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
                    end
                end
            end
            coms_pkg::CAL_DONE: begin
                // Counted whole seconds plus one, even with no partial second, never zero
                s_nxt.travel = s_r.sec_cnt + 16'h0001;
                s_nxt.st = coms_pkg::CAL_IDLE;
            end
            default: begin
                s_nxt.st = coms_pkg::CAL_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{st: coms_pkg::CAL_IDLE, travel: coms_pkg::TRAVEL_RST_S,
                     ms_cnt: 16'h0000, sec_cnt: 16'h0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign travel_s = s_r.travel;
    assign cal_busy = (s_r.st != coms_pkg::CAL_IDLE);

    a_travel_reset: assert property (@(posedge clk)
        $fell(rst) |-> travel_s == coms_pkg::TRAVEL_RST_S)
        else $error("travel time not 30 s after reset");

endmodule : coms_travel

// *** dv/coms_valve_model.sv ***
// Purpose: Motorised valve actuator on the far side of the control outputs
// Assumes: out1 drives the valve open, out2 drives it closed
// Notes: The valve moves one 10% step every STEP cycles, stops at the ends
`timescale 1ns/1ps
module coms_valve_model #(parameter int STEP = 8) (
    input wire logic clk,
    input wire logic open_drv,
    input wire logic close_drv,
    output logic full_open,
    output logic [3:0] pos
);
    int cnt = 0; // Free-running cycle count, wraps every STEP cycles whether or not the valve moves
    initial pos = 4'h0;
    // Move only while exactly one side is driven
    always @(posedge clk) begin
        cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
        if (cnt == STEP - 1 && open_drv && !close_drv && pos < 4'hA) begin
            pos <= pos + 4'h1;
        end else if (cnt == STEP - 1 && close_drv && !open_drv && pos > 4'h0) begin
            pos <= pos - 4'h1;
        end
    end
    assign full_open = (pos == 4'hA); // End switch at full stroke
endmodule : coms_valve_model

// *** dv/tb_control_output_method_select.sv ***
// Purpose: Self-checking bench for the output method select block
// Assumes: Wishbone answers one cycle after a taken request
// Notes: Calibration is run with the valve already at its end stop
`timescale 1ns/1ps
module tb_control_output_method_select;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, dout, q;
    logic ack, o1, o2, risk, fdis, full;
    logic [3:0] bar, pos;
    int fail_count = 0, samples_checked = 0;
    initial forever #25 clk = ~clk;
    coms_top dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .valve_full_pin(full), .valve_pos_pin(pos), .ctl_out1(o1), .ctl_out2(o2),
        .bumpless_risk(risk), .bar_graph(bar), .feat_disable(fdis));
    coms_valve_model valve (.clk(clk), .open_drv(o1), .close_drv(o2),
        .full_open(full), .pos(pos));
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One classic cycle: hold until ack is sampled high, release on that edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin fail_count++; print_verdict(); end
        q = dout;
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wb
    // Outputs are sampled four cycles after a write
    task outs(input string nm, input logic [1:0] e);
        repeat (4) @(posedge clk);
        chk(nm, {30'h0, o1, o2}, {30'h0, e});
    endtask : outs
    task t_reset;
        wb(0, coms_pkg::ADR_CTRL, 0); chk("ctrl", q & 32'hFF, 32'h0);
        wb(0, coms_pkg::ADR_TRAVEL, 0); chk("travel", q, 32'h1E);
        wb(0, coms_pkg::ADR_STOPMV, 0); chk("stopmv", q, 32'h0);
        wb(0, coms_pkg::ADR_GAIN, 0); chk("gain", q, 32'h0);
        wb(0, 8'hFC, 0); chk("unmapped", q, 32'h0);
        outs("out rst", 2'b00);
        $display("reset test done");
    endtask : t_reset
    task t_heatcool;
        wb(1, coms_pkg::ADR_CTRL, 32'h02);
        wb(1, coms_pkg::ADR_STOPMV, 32'hFF38); outs("stop neg", 2'b01);
        wb(1, coms_pkg::ADR_STOPMV, 32'h00C8); outs("stop pos", 2'b10);
        wb(1, coms_pkg::ADR_STOPMV, 32'h0); outs("stop zero", 2'b00);
        wb(1, coms_pkg::ADR_BAND, 32'hFFF6);
        wb(0, coms_pkg::ADR_BAND, 0); chk("band", q & 32'hFFFF, 32'hFFF6);
        chk("overlap", {31'h0, risk}, 32'h1);
        wb(1, coms_pkg::ADR_BAND, 32'h14);
        wb(1, coms_pkg::ADR_PROC, 32'h00C800C8);
        wb(1, coms_pkg::ADR_CTRL, 32'h0E); outs("dead", 2'b00);
        wb(1, coms_pkg::ADR_PROC, 32'h00C8012C); outs("cool on", 2'b01);
        wb(1, coms_pkg::ADR_CTRL, 32'h0A); outs("pid cool", 2'b01);
        wb(1, coms_pkg::ADR_BAND, 32'hFFF6);
        wb(1, coms_pkg::ADR_CTRL, 32'h0);
        wb(0, coms_pkg::ADR_BAND, 0); chk("band off", q, 32'h0);
        chk("norisk", {31'h0, risk}, 32'h0);
        $display("heat-cool test done");
    endtask : t_heatcool
    task t_onoff;
        wb(1, coms_pkg::ADR_HYST, 32'h00020002);
        wb(1, coms_pkg::ADR_PROC, 32'h00C80064);
        wb(1, coms_pkg::ADR_CTRL, 32'h0C); outs("rev", 2'b10);
        wb(1, coms_pkg::ADR_CTRL, 32'h1C); outs("dir", 2'b00);
        $display("on-off test done");
    endtask : t_onoff
    task t_position;
        wb(1, coms_pkg::ADR_VALVE, 32'h1);
        wb(1, coms_pkg::ADR_CTRL, 32'h87);
        wb(0, coms_pkg::ADR_CTRL, 0); chk("no onoff", q & 32'hFF, 32'h83);
        wb(0, coms_pkg::ADR_STAT, 0); chk("refused", q & 32'h8, 32'h8);
        chk("disable", {31'h0, fdis}, 32'h1);
        outs("open", 2'b10);
        repeat (120) @(posedge clk);
        chk("bar", {28'h0, bar}, 32'hA);
        wb(1, coms_pkg::ADR_CTRL, 32'hC3);
        wb(0, coms_pkg::ADR_STAT, 0); chk("cal busy", q & 32'h10, 32'h10);
        wb(0, coms_pkg::ADR_TRAVEL, 0); chk("cal travel", q, 32'h1);
        wb(1, coms_pkg::ADR_VALVE, 32'h2); outs("close", 2'b01);
        wb(1, coms_pkg::ADR_VALVE, 32'h0); outs("hold", 2'b00);
        wb(1, coms_pkg::ADR_TRAVEL, 32'h5);
        wb(0, coms_pkg::ADR_TRAVEL, 0); chk("travel", q, 32'h5);
        $display("position test done");
    endtask : t_position
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_heatcool();
        t_onoff();
        t_position();
        print_verdict();
    end
endmodule : tb_control_output_method_select
